// ==== logic/lid_cfg.svh ====
// Constants for the brightness and lamp-test block
// Assumes inclusion by the package and the design file only
`ifndef LID_CFG_SVH
`define LID_CFG_SVH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define LID_ADDR_BRIGHT_10  8'h01
`define LID_ADDR_BRIGHT_32  8'h02
`define LID_ADDR_LAMP_TEST  8'h07

// ----------------------------------------
// Field positions and codes
// ----------------------------------------
`define LID_HI_MSB          7
`define LID_HI_LSB          4
`define LID_LO_MSB          3
`define LID_LO_LSB          0
`define LID_TEST_BIT        0
`define LID_CODE_MAX        4'hE
`define LID_TEST_CODE       4'h6
`define LID_BRIGHT_RESET    8'h00
`define LID_TEST_RESET      1'b0
`define LID_PHASE_LAST      4'hF
`define LID_SLOT_LAST_TEST  3'h7
`define LID_SLOT_LAST_NORM  3'h3

// ----------------------------------------
// Scan steps, digit slots and read padding
// ----------------------------------------
`define LID_PHASE_FIRST     4'h0
`define LID_PHASE_STEP      4'h1
`define LID_PHASE_HALF      4'h8
`define LID_SLOT_FIRST      3'h0
`define LID_SLOT_STEP       3'h1
`define LID_SLOT_DIGIT1     3'h1
`define LID_SLOT_DIGIT2     3'h2
`define LID_SLOT_DIGIT3     3'h3
`define LID_CODE_MIN        4'h0
`define LID_CODE_SEVEN      4'h7
`define LID_CODE_FULL       4'hF
`define LID_PAD_LSB         1
`define LID_TEST_PAD        7'h00
`define LID_READ_NONE       8'h00

`endif

// ==== logic/lid_pkg.sv ====
// Types for the brightness and lamp-test block
// Assumes lid_cfg.svh sits beside it
`default_nettype none
`include "lid_cfg.svh"
package lid_pkg;
    typedef logic [3:0] lid_code_t;
    typedef struct packed {
        logic [7:0] bright_10;
        logic [7:0] bright_32;
        logic       test_on;
        logic [3:0] phase;
        logic [2:0] slot;
    } lid_state_t;
endpackage : lid_pkg
`default_nettype wire

// ==== logic/lid_display_pwm.sv ====
// Brightness registers, lamp-test register and per-digit PWM gate
// Assumes a same-clock register write port and a scan tick from the driver
//
// Behaviour
// - Upper nibbles give digit 1 and digit 3 duty; code zero is one sixteenth.
// - Each code step adds one sixteenth of on-time, up to code fourteen.
// - Codes fourteen and fifteen both give fifteen sixteenths, never full duty.
// - Register seven bit 0 selects lamp test; bits 7 to 1 ignored.
// - Lamp test lights everything, eight digits, seven sixteenths duty.
// - Lamp test overrides without altering registers; clearing restores settings.
// - Lower nibbles give digit 0 and digit 2 duty, same encoding.
`default_nettype none
`include "lid_cfg.svh"
module lid_display_pwm
    import lid_pkg::*;
(
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    // Register write and read ports
    input  wire logic       wr_en_i,
    input  wire logic [7:0] wr_addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic [7:0] rd_addr_i,
    output logic      [7:0] rd_data_o,
    // Scan timing
    input  wire logic       part_tick_i,
    // Scanner side
    output logic      [2:0] slot_o,
    output logic            seg_on_o,
    output logic            test_active_o,
    output logic      [3:0] duty_d0_o,
    output logic      [3:0] duty_d1_o,
    output logic      [3:0] duty_d2_o,
    output logic      [3:0] duty_d3_o
);

    // ----------------------------------------
    // State
    // ----------------------------------------
    lid_state_t st;
    lid_state_t next_st;
    lid_code_t  code_raw;
    lid_code_t  code_now;
    logic [2:0] slot_last;
    logic       hit_bright_10;
    logic       hit_bright_32;
    logic       hit_lamp_test;
    logic       slot_end;

    localparam lid_state_t ST_RESET = '{
        bright_10: `LID_BRIGHT_RESET,
        bright_32: `LID_BRIGHT_RESET,
        test_on:   `LID_TEST_RESET,
        phase:     `LID_PHASE_FIRST,
        slot:      `LID_SLOT_FIRST
    };

    function automatic lid_code_t clip(input lid_code_t c);
        clip = (c > `LID_CODE_MAX) ? `LID_CODE_MAX : c;
    endfunction : clip

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    // Unmapped addresses match nothing and change nothing
    assign hit_bright_10 = wr_en_i && (wr_addr_i == `LID_ADDR_BRIGHT_10);
    assign hit_bright_32 = wr_en_i && (wr_addr_i == `LID_ADDR_BRIGHT_32);
    assign hit_lamp_test = wr_en_i && (wr_addr_i == `LID_ADDR_LAMP_TEST);
    assign slot_end      = part_tick_i && (st.phase == `LID_PHASE_LAST);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        next_st   = st;
        slot_last = st.test_on ? `LID_SLOT_LAST_TEST : `LID_SLOT_LAST_NORM;
        // Lamp-test writes never touch the brightness values
        if (hit_bright_10) begin
            next_st.bright_10 = wr_data_i;
        end
        if (hit_bright_32) begin
            next_st.bright_32 = wr_data_i;
        end
        if (hit_lamp_test) begin
            next_st.test_on = wr_data_i[`LID_TEST_BIT];
        end
        if (part_tick_i) begin
            next_st.phase = st.phase + `LID_PHASE_STEP;
        end
        if (slot_end) begin
            next_st.slot = (st.slot >= slot_last) ? `LID_SLOT_FIRST : st.slot + `LID_SLOT_STEP;
        end
        // Leaving lamp test in slots 4 to 7 restarts at digit 0; no stale slot may light
        if (!next_st.test_on && (next_st.slot > `LID_SLOT_LAST_NORM)) begin
            next_st.slot = `LID_SLOT_FIRST;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // Duty selection and gate
    // ----------------------------------------
    // Slot bit 2 only occurs in lamp test, where the code is fixed anyway
    always_comb begin
        unique case (st.slot[1:0])
            2'd0:    code_raw = st.bright_10[`LID_LO_MSB:`LID_LO_LSB];
            2'd1:    code_raw = st.bright_10[`LID_HI_MSB:`LID_HI_LSB];
            2'd2:    code_raw = st.bright_32[`LID_LO_MSB:`LID_LO_LSB];
            default: code_raw = st.bright_32[`LID_HI_MSB:`LID_HI_LSB];
        endcase
    end

    always_comb begin
        if (st.test_on) begin
            code_now = `LID_TEST_CODE;
        end else begin
            code_now = clip(code_raw);
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // On for code+1 parts; phase 15 always dark
    assign seg_on_o      = (st.phase <= code_now);
    assign slot_o        = st.slot;
    assign test_active_o = st.test_on;
    assign duty_d0_o     = st.bright_10[`LID_LO_MSB:`LID_LO_LSB];
    assign duty_d1_o     = st.bright_10[`LID_HI_MSB:`LID_HI_LSB];
    assign duty_d2_o     = st.bright_32[`LID_LO_MSB:`LID_LO_LSB];
    assign duty_d3_o     = st.bright_32[`LID_HI_MSB:`LID_HI_LSB];

    // ----------------------------------------
    // Read back
    // ----------------------------------------
    always_comb begin
        unique case (rd_addr_i)
            `LID_ADDR_BRIGHT_10: rd_data_o = st.bright_10;
            `LID_ADDR_BRIGHT_32: rd_data_o = st.bright_32;
            `LID_ADDR_LAMP_TEST: rd_data_o = {`LID_TEST_PAD, st.test_on};
            default:             rd_data_o = `LID_READ_NONE;
        endcase
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_dark_last_part: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st.phase == `LID_PHASE_LAST
        |-> !seg_on_o) else $error("segments lit in blanking part");
    a_first_part_on: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st.phase == `LID_PHASE_FIRST
        |-> seg_on_o) else $error("minimum on-time missing");
    a_test_duty: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st.test_on
        |-> seg_on_o == (st.phase <= `LID_TEST_CODE)) else $error("test duty not seven sixteenths");
    a_duty_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !st.test_on && st.slot == `LID_SLOT_DIGIT1 && st.bright_10[`LID_HI_MSB:`LID_HI_LSB] == `LID_CODE_SEVEN
        |-> seg_on_o == (st.phase < `LID_PHASE_HALF)) else $error("code seven not eight sixteenths");
    a_test_keeps: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st.test_on && !hit_bright_10 && !hit_bright_32
        |=> $stable(st.bright_10) && $stable(st.bright_32)) else $error("test altered brightness");
    a_test_bit_only: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        hit_lamp_test
        |=> test_active_o == $past(wr_data_i[`LID_TEST_BIT])) else $error("lamp test bit not taken");
    a_normal_slots: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !st.test_on
        |-> st.slot <= `LID_SLOT_LAST_NORM) else $error("normal scan past four digits");
    a_low_nibble: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !st.test_on && st.slot == `LID_SLOT_DIGIT2 && st.bright_32[`LID_LO_MSB:`LID_LO_LSB] == `LID_CODE_MIN
        |-> seg_on_o == (st.phase == `LID_PHASE_FIRST)) else $error("digit two duty wrong");
    a_lamp_write_keeps: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        hit_lamp_test
        |=> $stable(st.bright_10) && $stable(st.bright_32)) else $error("lamp write altered brightness");
    a_code_zero_one: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !st.test_on && st.slot == `LID_SLOT_DIGIT1 && st.bright_10[`LID_HI_MSB:`LID_HI_LSB] == `LID_CODE_MIN
        |-> seg_on_o == (st.phase == `LID_PHASE_FIRST)) else $error("digit one code zero wrong");
    a_top_code_full: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !st.test_on && st.slot == `LID_SLOT_DIGIT3 && st.bright_32[`LID_HI_MSB:`LID_HI_LSB] == `LID_CODE_FULL
        && st.phase == `LID_CODE_MAX |-> seg_on_o) else $error("code fifteen short of maximum");
    a_top_code_max: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !st.test_on && st.slot == `LID_SLOT_DIGIT2 && st.bright_32[`LID_LO_MSB:`LID_LO_LSB] == `LID_CODE_MAX
        && st.phase == `LID_CODE_MAX |-> seg_on_o) else $error("code fourteen short of maximum");
    a_digit3_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !st.test_on && st.slot == `LID_SLOT_DIGIT3 && st.bright_32[`LID_HI_MSB:`LID_HI_LSB] == `LID_CODE_SEVEN
        |-> seg_on_o == (st.phase < `LID_PHASE_HALF)) else $error("digit three code seven wrong");
    a_test_all_on: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st.test_on && st.phase == `LID_PHASE_FIRST
        |-> seg_on_o) else $error("lamp test slot dark");
    a_test_wraps: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st.test_on && slot_end && st.slot == `LID_SLOT_LAST_TEST
        |=> st.slot == `LID_SLOT_FIRST) else $error("lamp test scan not wrapping after eight");
    a_test_slot_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        st.test_on && slot_end && st.slot < `LID_SLOT_LAST_TEST && !hit_lamp_test
        |=> st.slot == $past(st.slot) + `LID_SLOT_STEP) else $error("lamp test slot skipped");
    a_normal_wraps: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !st.test_on && slot_end && st.slot == `LID_SLOT_LAST_NORM
        |=> st.slot == `LID_SLOT_FIRST) else $error("normal scan not wrapping after four");
    a_slot_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !slot_end && !hit_lamp_test
        |=> $stable(st.slot)) else $error("slot moved inside its sixteen parts");
    a_phase_step: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        part_tick_i
        |=> st.phase == $past(st.phase) + `LID_PHASE_STEP) else $error("part tick not counted");
    a_phase_holds: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        !part_tick_i
        |=> $stable(st.phase)) else $error("phase moved without tick");
    a_read_test_pad: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_addr_i == `LID_ADDR_LAMP_TEST
        |-> rd_data_o[`LID_HI_MSB:`LID_PAD_LSB] == `LID_TEST_PAD) else $error("ignored test bits read back");

endmodule : lid_display_pwm
`default_nettype wire

// ==== testbench/lid_host.sv ====
// Host model: register writes and scan part ticks
// Assumes one clock shared with the block
`default_nettype none
module lid_host (
    // Clock and reset
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    // Writes and ticks
    output logic            wr_en_o,
    output logic      [7:0] wr_addr_o,
    output logic      [7:0] wr_data_o,
    output logic            part_tick_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Ticks on every other edge, off in reset
    // ----------------------------------------
    initial begin
        wr_en_o = 1'b0;
    end
    always_ff @(posedge sys_clk_i) part_tick_o <= rst_n_i & ~part_tick_o;
    task automatic write(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        {wr_en_o, wr_addr_o, wr_data_o} <= {1'b1, a, d};
        @(posedge sys_clk_i);
        // Released lines do not keep the last value
        {wr_en_o, wr_addr_o, wr_data_o} <= {1'b0, ~a, ~d};
    endtask : write
endmodule : lid_host
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench for the brightness and lamp-test block
// Assumes the host model drives writes and ticks
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    logic       sys_clk_i = 1'b0, rst_n_i = 1'b0, wr_en, tick, seg_on, test_act;
    logic [7:0] wr_addr, wr_data, rd_data, rd_addr = 8'h00;
    logic [2:0] slot;
    logic [3:0] d0, d1, d2, d3;
    int         mismatches = 0, checks = 0, cnt [8];
    always #50 sys_clk_i = ~sys_clk_i;
    lid_host host_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wr_en_o(wr_en), .wr_addr_o(wr_addr),
                     .wr_data_o(wr_data), .part_tick_o(tick));
    lid_display_pwm dut_u (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en), .wr_addr_i(wr_addr),
        .wr_data_i(wr_data), .rd_addr_i(rd_addr), .rd_data_o(rd_data), .part_tick_i(tick), .slot_o(slot),
        .seg_on_o(seg_on), .test_active_o(test_act), .duty_d0_o(d0), .duty_d1_o(d1), .duty_d2_o(d2),
        .duty_d3_o(d3));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk_i);
        rd_addr <= a;
        @(negedge sys_clk_i);
        chk("rd_data_o", e, rd_data);
    endtask : rd
    // Whole scan periods, so the start phase does not matter
    task automatic t_scan(input logic [7:0] b10, input logic [7:0] b32, input int n);
        logic [3:0] c [8];
        c = '{b10[3:0], b10[7:4], b32[3:0], b32[7:4], 4'h0, 4'h0, 4'h0, 4'h0};
        cnt = '{default: 0};
        repeat (n) begin
            @(negedge sys_clk_i);
            if (tick && seg_on) cnt[slot]++;
        end
        for (int i = 0; i < 8; i++) chk("on_parts", 8'(i > 3 ? 0 : c[i] > 4'hE ? 15 : c[i] + 1), 8'(cnt[i]));
        chk("duty_d", b10, {d1, d0});
        chk("duty_d", b32, {d3, d2});
    endtask : t_scan
    task automatic t_reset();
        rd(8'h01, 8'h00);
        rd(8'h07, 8'h00);
    endtask : t_reset
    task automatic t_duty(input logic [7:0] b10, input logic [7:0] b32);
        host_u.write(8'h01, b10);
        host_u.write(8'h02, b32);
        rd(8'h02, b32);
        t_scan(b10, b32, 128);
    endtask : t_duty
    task automatic t_test();
        host_u.write(8'h03, 8'hFF);
        host_u.write(8'h07, 8'hFE);
        rd(8'h07, 8'h00);
        host_u.write(8'h07, 8'hFF);
        rd(8'h07, 8'h01);
        chk("test_active_o", 8'h01, {7'h0, test_act});
        cnt = '{default: 0};
        repeat (256) begin
            @(negedge sys_clk_i);
            if (tick && seg_on) cnt[slot]++;
        end
        for (int i = 0; i < 8; i++) chk("test_parts", 8'h07, 8'(cnt[i]));
        rd(8'h01, 8'hDC);
        host_u.write(8'h07, 8'h00);
        rd(8'h03, 8'h00);
        t_scan(8'hDC, 8'hFE, 128);
    endtask : t_test
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : finish_test
    initial begin
        repeat (8) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_duty(8'h70, 8'hE0);
        t_duty(8'h07, 8'h0E);
        for (int k = 0; k < 16; k += 4) t_duty({4'(k + 1), 4'(k)}, {4'(k + 3), 4'(k + 2)});
        t_test();
        finish_test();
    end
endmodule : testbench
`default_nettype wire
